/* File: rtl/lcdpg_top.sv */
// segment/port select and output gate of the lcd driver, with its apb register slave
// assumes: single 100 mhz clock; dot data, scan data and the two extra reset requests
// come from logic on the same clock, so they are not synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "lcdpg_map.svh"
module lcdpg_top #(
  parameter int unsigned PHASE_CYC = `LCDPG_PHASE_CYC
) (
  // clock and power-on reset
  input wire logic clk,
  input wire logic rst,
  // further reset requests, one-cycle or level, same clock
  input wire logic clkstop_rst,
  input wire logic chipen_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // dot data from the segment data registers, two dots per line
  input wire logic [29:0] dot_a,
  input wire logic [29:0] dot_b,
  // key scan source data for lines 0..15
  input wire logic [15:0] scan_source_line,
  // pins
  output lcdpg_pkg::lcdpg_lvl_t com0_ff,
  output lcdpg_pkg::lcdpg_lvl_t com1_ff,
  output logic [29:0] lcd_line_ff,
  output logic scan_active_ff
);

  // ----------------------------------------
  // register state
  // ----------------------------------------
  lcdpg_pkg::lcdpg_sel_t segment_port_group_select_ff;
  lcdpg_pkg::lcdpg_mode_t display_mode_control_ff;
  logic [3:0] port_f_ff;
  logic [3:0] port_e_ff;
  logic [5:0] port_x_ff;
  logic [15:0] wide_shared_port_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic setup_ph;
  logic wr_done;
  logic [7:0] idx;
  logic addr_ok;
  logic hit;
  logic [31:0] rd_mux;
  logic [15:0] wdata_m;
  lcdpg_pkg::lcdpg_slot_t slot;
  logic scan_win;

  assign setup_ph = psel & ~penable;
  // write lands on the edge that samples pready high
  assign wr_done = psel & penable & pready_ff & pwrite & ~pslverr_ff;
  assign idx = paddr[9:2];
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[31:10] == 22'h00_0000);
  assign wdata_m = {{8{pstrb[1]}}, {8{pstrb[0]}}} & pwdata[15:0];

  // register hit check and read mux; unused upper bits read zero
  always_comb begin
    hit = addr_ok;
    rd_mux = 32'h0000_0000;
    case (idx)
      `LCDPG_IDX_SEL: rd_mux = {28'h000_0000, segment_port_group_select_ff};
      `LCDPG_IDX_MODE: rd_mux = {30'h0000_0000, display_mode_control_ff};
      `LCDPG_IDX_PORT_F: rd_mux = {28'h000_0000, port_f_ff};
      `LCDPG_IDX_PORT_E: rd_mux = {28'h000_0000, port_e_ff};
      `LCDPG_IDX_PORT_X: rd_mux = {26'h000_0000, port_x_ff};
      `LCDPG_IDX_PORT_Y: rd_mux = {16'h0000, wide_shared_port_ff};
      `LCDPG_IDX_STATUS: rd_mux = {28'h000_0000, scan_active_ff, display_mode_control_ff.display_drive_on, slot};
      default: hit = 1'b0;
    endcase
    if (!addr_ok) begin
      rd_mux = 32'h0000_0000;
    end
  end

  // zero-wait answer: ready rises in the first access cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else if (setup_ph) begin
      pready_ff <= 1'b1;
      pslverr_ff <= ~hit | (pwrite & (idx == `LCDPG_IDX_STATUS));
      prdata_ff <= (pwrite || !hit) ? 32'h0000_0000 : rd_mux;
    end else begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign prdata = prdata_ff;

  // ----------------------------------------
  // control registers
  // ----------------------------------------

  // group select; chip-enable reset leaves it alone on purpose
  always_ff @(posedge clk) begin
    if (rst || clkstop_rst) begin
      segment_port_group_select_ff <= `LCDPG_SEL_RST;
    end else if (wr_done && idx == `LCDPG_IDX_SEL && pstrb[0]) begin
      segment_port_group_select_ff <= pwdata[3:0];
    end
  end

  // mode flags; cleared by power-on and clock stop, kept by chip enable
  always_ff @(posedge clk) begin
    if (rst || clkstop_rst) begin
      display_mode_control_ff <= `LCDPG_MODE_RST;
    end else if (wr_done && idx == `LCDPG_IDX_MODE && pstrb[0]) begin
      display_mode_control_ff <= pwdata[1:0];
    end
  end

  // port output latches; byte lanes honoured
  always_ff @(posedge clk) begin
    if (rst) begin
      port_f_ff <= 4'h0;
      port_e_ff <= 4'h0;
      port_x_ff <= 6'h00;
      wide_shared_port_ff <= `LCDPG_PORT_RST;
    end else if (wr_done) begin
      if (idx == `LCDPG_IDX_PORT_F && pstrb[0]) begin
        port_f_ff <= wdata_m[3:0];
      end
      if (idx == `LCDPG_IDX_PORT_E && pstrb[0]) begin
        port_e_ff <= wdata_m[3:0];
      end
      if (idx == `LCDPG_IDX_PORT_X && pstrb[0]) begin
        port_x_ff <= wdata_m[5:0];
      end
      if (idx == `LCDPG_IDX_PORT_Y) begin
        if (pstrb[0]) begin
          wide_shared_port_ff[7:0] <= wdata_m[7:0];
        end
        if (pstrb[1]) begin
          wide_shared_port_ff[15:8] <= wdata_m[15:8];
        end
      end
    end
  end

  // chip-enable reset has no state of its own to clear here
  logic chipen_seen;
  assign chipen_seen = chipen_rst;

  // ----------------------------------------
  // waveform timing
  // ----------------------------------------
  lcdpg_wave #(
    .PHASE_CYC(PHASE_CYC)
  ) u_wave (
    .clk(clk),
    .rst(rst | chipen_seen),
    .run(display_mode_control_ff.display_drive_on | display_mode_control_ff.scan_source_on),
    .slot_ff(slot),
    .scan_win_ff(scan_win)
  );

  // scan only while enabled and inside the window
  logic scan_act;
  assign scan_act = display_mode_control_ff.scan_source_on & scan_win;

  // ----------------------------------------
  // per-group line selection
  // ----------------------------------------
  logic [29:0] line_nxt;

  lcdpg_pinsel #(
    .W(16)
  ) u_grp_y (
    .port_sel(segment_port_group_select_ff.y),
    .drive_on(display_mode_control_ff.display_drive_on),
    .scan_act(scan_act),
    .slot(slot),
    .port_val(wide_shared_port_ff),
    .scan_val(scan_source_line),
    .dot_a(dot_a[15:0]),
    .dot_b(dot_b[15:0]),
    .line(line_nxt[15:0])
  );

  lcdpg_pinsel #(
    .W(6)
  ) u_grp_x (
    .port_sel(segment_port_group_select_ff.x),
    .drive_on(display_mode_control_ff.display_drive_on),
    .scan_act(1'b0),
    .slot(slot),
    .port_val(port_x_ff),
    .scan_val(6'h00),
    .dot_a(dot_a[21:16]),
    .dot_b(dot_b[21:16]),
    .line(line_nxt[21:16])
  );

  lcdpg_pinsel #(
    .W(4)
  ) u_grp_e (
    .port_sel(segment_port_group_select_ff.e),
    .drive_on(display_mode_control_ff.display_drive_on),
    .scan_act(1'b0),
    .slot(slot),
    .port_val(port_e_ff),
    .scan_val(4'h0),
    .dot_a(dot_a[25:22]),
    .dot_b(dot_b[25:22]),
    .line(line_nxt[25:22])
  );

  lcdpg_pinsel #(
    .W(4)
  ) u_grp_f (
    .port_sel(segment_port_group_select_ff.f),
    .drive_on(display_mode_control_ff.display_drive_on),
    .scan_act(1'b0),
    .slot(slot),
    .port_val(port_f_ff),
    .scan_val(4'h0),
    .dot_a(dot_a[29:26]),
    .dot_b(dot_b[29:26]),
    .line(line_nxt[29:26])
  );

  // ----------------------------------------
  // common waveform
  // ----------------------------------------
  lcdpg_pkg::lcdpg_lvl_t com0_nxt;
  lcdpg_pkg::lcdpg_lvl_t com1_nxt;

  // each common is selected in its own slot, half level in the other's
  always_comb begin
    case (slot)
      lcdpg_pkg::LCDPG_SLOT_A_POS: begin
        com0_nxt = lcdpg_pkg::LCDPG_LVL_FULL;
        com1_nxt = lcdpg_pkg::LCDPG_LVL_HALF;
      end
      lcdpg_pkg::LCDPG_SLOT_B_POS: begin
        com0_nxt = lcdpg_pkg::LCDPG_LVL_HALF;
        com1_nxt = lcdpg_pkg::LCDPG_LVL_FULL;
      end
      lcdpg_pkg::LCDPG_SLOT_A_NEG: begin
        com0_nxt = lcdpg_pkg::LCDPG_LVL_GND;
        com1_nxt = lcdpg_pkg::LCDPG_LVL_HALF;
      end
      lcdpg_pkg::LCDPG_SLOT_B_NEG: begin
        com0_nxt = lcdpg_pkg::LCDPG_LVL_HALF;
        com1_nxt = lcdpg_pkg::LCDPG_LVL_GND;
      end
      default: begin
        com0_nxt = lcdpg_pkg::LCDPG_LVL_GND;
        com1_nxt = lcdpg_pkg::LCDPG_LVL_GND;
      end
    endcase
  end

  // ----------------------------------------
  // output registers
  // ----------------------------------------

  // commons follow the slot only while the display is on, else held low
  always_ff @(posedge clk) begin
    if (rst) begin
      com0_ff <= lcdpg_pkg::LCDPG_LVL_GND;
      com1_ff <= lcdpg_pkg::LCDPG_LVL_GND;
    end else if (display_mode_control_ff.display_drive_on) begin
      com0_ff <= com0_nxt;
      com1_ff <= com1_nxt;
    end else begin
      com0_ff <= lcdpg_pkg::LCDPG_LVL_GND;
      com1_ff <= lcdpg_pkg::LCDPG_LVL_GND;
    end
  end

  // lines registered so a select write shows one edge after it lands
  always_ff @(posedge clk) begin
    if (rst) begin
      lcd_line_ff <= 30'h0000_0000;
      scan_active_ff <= 1'b0;
    end else begin
      lcd_line_ff <= line_nxt;
      scan_active_ff <= scan_act & ~segment_port_group_select_ff.y;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/lcdpg_map.svh */
// offsets, field positions, reset values and timing counts of the segment/port select block
// assumes: included by bare name from the rtl and tb files of this block
//
// Summary of operation
// - select flag one makes group port output
// - bit 0 switches lines 26..29 (group f)
// - bit 1 switches lines 22..25 (group e)
// - bit 2 switches lines 16..21 (group x)
// - bit 3 switches lines 0..15 (group y)
// - port value overrides segment and scan on y
// - drive waveforms only while display on
// - display off holds common and segment low
// - scan signals only while scan enable set
// - select flags in 4-bit rw register 11h
// - power-on, clock-stop clear; chip-enable keeps
// - half duty, half bias, 2 ms phases
`ifndef LCDPG_MAP_SVH
`define LCDPG_MAP_SVH

// ----------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------
`define LCDPG_IDX_SEL 8'h11
`define LCDPG_IDX_MODE 8'h12
`define LCDPG_IDX_PORT_F 8'h13
`define LCDPG_IDX_PORT_E 8'h14
`define LCDPG_IDX_PORT_X 8'h15
`define LCDPG_IDX_PORT_Y 8'h16
`define LCDPG_IDX_STATUS 8'h17

// ----------------------------------------
// field positions
// ----------------------------------------
`define LCDPG_SEL_F_BIT 0
`define LCDPG_SEL_E_BIT 1
`define LCDPG_SEL_X_BIT 2
`define LCDPG_SEL_Y_BIT 3
`define LCDPG_MODE_DRIVE_BIT 0
`define LCDPG_MODE_SCAN_BIT 1

// ----------------------------------------
// reset values
// ----------------------------------------
`define LCDPG_SEL_RST 4'h0
`define LCDPG_MODE_RST 2'h0
`define LCDPG_PORT_RST 16'h0000

// ----------------------------------------
// timing
// ----------------------------------------
`define LCDPG_CLK_KHZ 100000
`define LCDPG_PHASE_MS 2
`define LCDPG_FRAME_HZ 250
`define LCDPG_PHASE_CYC (`LCDPG_PHASE_MS * `LCDPG_CLK_KHZ)
`define LCDPG_SCAN_WIN_CYC 16

`endif

/* File: rtl/lcdpg_pkg.sv */
// types shared by the segment/port select block
// assumes: compiled before every module of the block
package lcdpg_pkg;

  // group select flags, bit 3 down to bit 0
  typedef struct packed {
    logic y;
    logic x;
    logic e;
    logic f;
  } lcdpg_sel_t;

  // mode register bits
  typedef struct packed {
    logic scan_source_on;
    logic display_drive_on;
  } lcdpg_mode_t;

  // level code of a three-level common pin
  typedef enum logic [1:0] {
    LCDPG_LVL_GND = 2'b00,
    LCDPG_LVL_HALF = 2'b01,
    LCDPG_LVL_FULL = 2'b10
  } lcdpg_lvl_t;

  // waveform slot sequence, 2 ms each
  typedef enum logic [1:0] {
    LCDPG_SLOT_A_POS = 2'b00,
    LCDPG_SLOT_B_POS = 2'b01,
    LCDPG_SLOT_A_NEG = 2'b10,
    LCDPG_SLOT_B_NEG = 2'b11
  } lcdpg_slot_t;

endpackage

/* File: rtl/lcdpg_wave.sv */
// slot timer of the display waveform: steps through four 2 ms slots
// assumes: one clock; run comes from registers on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "lcdpg_map.svh"
module lcdpg_wave #(
  parameter int unsigned PHASE_CYC = `LCDPG_PHASE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic run,
  // timing state
  output lcdpg_pkg::lcdpg_slot_t slot_ff,
  output logic scan_win_ff
);

  logic [31:0] cnt_ff;
  lcdpg_pkg::lcdpg_slot_t nxt_slot;

  // next slot in sequence
  always_comb begin
    case (slot_ff)
      lcdpg_pkg::LCDPG_SLOT_A_POS: nxt_slot = lcdpg_pkg::LCDPG_SLOT_B_POS;
      lcdpg_pkg::LCDPG_SLOT_B_POS: nxt_slot = lcdpg_pkg::LCDPG_SLOT_A_NEG;
      lcdpg_pkg::LCDPG_SLOT_A_NEG: nxt_slot = lcdpg_pkg::LCDPG_SLOT_B_NEG;
      lcdpg_pkg::LCDPG_SLOT_B_NEG: nxt_slot = lcdpg_pkg::LCDPG_SLOT_A_POS;
      default: nxt_slot = lcdpg_pkg::LCDPG_SLOT_A_POS;
    endcase
  end

  // slot counter; held at the first slot while stopped so a restart is clean
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      cnt_ff <= 32'h0000_0000;
      slot_ff <= lcdpg_pkg::LCDPG_SLOT_A_POS;
    end else if (cnt_ff == PHASE_CYC - 1) begin
      cnt_ff <= 32'h0000_0000;
      slot_ff <= nxt_slot;
    end else begin
      cnt_ff <= cnt_ff + 32'h0000_0001;
    end
  end

  // key scan window opens at the start of every slot
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      scan_win_ff <= 1'b0;
    end else begin
      scan_win_ff <= (cnt_ff < 32'(`LCDPG_SCAN_WIN_CYC));
    end
  end

endmodule
`default_nettype wire

/* File: rtl/lcdpg_pinsel.sv */
// per-line choice among port latch, scan source and segment waveform
// assumes: all inputs come from logic on the same clock; output is registered by the caller
`timescale 1ns/1ps
`default_nettype none
module lcdpg_pinsel #(
  parameter int unsigned W = 4
) (
  // group controls
  input wire logic port_sel,
  input wire logic drive_on,
  input wire logic scan_act,
  input wire lcdpg_pkg::lcdpg_slot_t slot,
  // per-line values
  input wire logic [W-1:0] port_val,
  input wire logic [W-1:0] scan_val,
  input wire logic [W-1:0] dot_a,
  input wire logic [W-1:0] dot_b,
  // line level
  output logic [W-1:0] line
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_line
      logic seg;
      // a lit dot sits opposite its common: low against a high common, high against a low one
      always_comb begin
        case (slot)
          lcdpg_pkg::LCDPG_SLOT_A_POS: seg = ~dot_a[i];
          lcdpg_pkg::LCDPG_SLOT_B_POS: seg = ~dot_b[i];
          lcdpg_pkg::LCDPG_SLOT_A_NEG: seg = dot_a[i];
          lcdpg_pkg::LCDPG_SLOT_B_NEG: seg = dot_b[i];
          default: seg = 1'b0;
        endcase
      end
      // port first, then scan window, then segment or low when display is off
      assign line[i] = port_sel ? port_val[i] :
                       scan_act ? scan_val[i] :
                       (drive_on & seg);
    end
  endgenerate

endmodule
`default_nettype wire

/* File: tb/lcdpg_monitor.sv */
// concurrent checks on the pins and apb port of lcdpg_top
// assumes: bound into lcdpg_top; register copies are rebuilt from accepted apb writes with full strobes
`timescale 1ns/1ps
`default_nettype none
`include "lcdpg_map.svh"
module lcdpg_monitor #(
  parameter int unsigned PHASE_CYC = 8
) (
  // clock and resets
  input wire logic clk,
  input wire logic rst,
  input wire logic clkstop_rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // data and pins
  input wire logic [29:0] dot_a,
  input wire logic [15:0] scan_source_line,
  input wire lcdpg_pkg::lcdpg_lvl_t com0_ff,
  input wire lcdpg_pkg::lcdpg_lvl_t com1_ff,
  input wire logic [29:0] lcd_line_ff,
  input wire logic scan_active_ff
);
  // ----------------
  // register copies
  // ----------------
  logic wr_ok;
  logic [7:0] idx;
  logic [3:0] sel_s;
  logic [1:0] mode_s;
  logic [29:0] latch_s;
  int unsigned full_cnt;
  logic from_half;
  assign wr_ok = psel && penable && pwrite && pready && !pslverr;
  assign idx = paddr[9:2];
  // select and mode; the clock-stop request clears them like power-on
  always_ff @(posedge clk) begin
    if (rst || clkstop_rst) begin
      sel_s <= 4'h0;
      mode_s <= 2'h0;
    end else if (wr_ok && idx == `LCDPG_IDX_SEL) begin
      sel_s <= pwdata[3:0];
    end else if (wr_ok && idx == `LCDPG_IDX_MODE) begin
      mode_s <= pwdata[1:0];
    end
  end
  // port latches, bit n belongs to line n; only power-on clears them
  always_ff @(posedge clk) begin
    if (rst) begin
      latch_s <= 30'h0;
    end else if (wr_ok) begin
      case (idx)
        `LCDPG_IDX_PORT_F: latch_s[29:26] <= pwdata[3:0];
        `LCDPG_IDX_PORT_E: latch_s[25:22] <= pwdata[3:0];
        `LCDPG_IDX_PORT_X: latch_s[21:16] <= pwdata[5:0];
        `LCDPG_IDX_PORT_Y: latch_s[15:0] <= pwdata[15:0];
        default: ;
      endcase
    end
  end
  // run length of com0 at full level; only runs entered from half level are whole slots
  always_ff @(posedge clk) begin
    if (rst || com0_ff != lcdpg_pkg::LCDPG_LVL_FULL) begin
      full_cnt <= '0;
      from_half <= (com0_ff == lcdpg_pkg::LCDPG_LVL_HALF);
    end else begin
      full_cnt <= full_cnt + 1;
    end
  end
  // ----------------
  // assertions
  // ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_group_f_port: assert property (
    $past(sel_s[0]) |-> lcd_line_ff[29:26] == $past(latch_s[29:26])) else $error("group f differs from latch");
  chk_group_e_port: assert property (
    $past(sel_s[1]) |-> lcd_line_ff[25:22] == $past(latch_s[25:22])) else $error("group e differs from latch");
  chk_group_x_port: assert property (
    $past(sel_s[2]) |-> lcd_line_ff[21:16] == $past(latch_s[21:16])) else $error("group x differs from latch");
  chk_group_y_port: assert property (
    $past(sel_s[3]) |-> lcd_line_ff[15:0] == $past(latch_s[15:0])) else $error("group y differs from latch");
  chk_off_com_low: assert property (
    !$past(mode_s[0]) |-> com0_ff == lcdpg_pkg::LCDPG_LVL_GND && com1_ff == lcdpg_pkg::LCDPG_LVL_GND)
    else $error("common driven while display off");
  chk_off_seg_low: assert property (
    !$past(mode_s[0]) && !$past(sel_s[0]) |-> lcd_line_ff[29:26] == 4'h0) else $error("segment driven while off");
  chk_on_slot_seg: assert property (
    $past(mode_s[0]) && !$past(sel_s[0]) && com0_ff == lcdpg_pkg::LCDPG_LVL_FULL
    |-> lcd_line_ff[29:26] == ~$past(dot_a[29:26])) else $error("segment level wrong in first slot");
  chk_scan_gate: assert property (
    scan_active_ff |-> $past(mode_s[1])) else $error("scan active while scan off");
  chk_scan_data: assert property (
    scan_active_ff && !$past(sel_s[3]) |-> lcd_line_ff[15:0] == $past(scan_source_line))
    else $error("scan lines differ from scan source");
  chk_slot_length: assert property (
    $past(com0_ff) == lcdpg_pkg::LCDPG_LVL_FULL && com0_ff != lcdpg_pkg::LCDPG_LVL_FULL && from_half
    && $past(mode_s[0]) |-> full_cnt == PHASE_CYC) else $error("slot length wrong");
  chk_apb_answer: assert property (
    psel && !penable |=> pready ##1 !pready) else $error("apb answer not a one-cycle pulse after setup");
endmodule
`default_nettype wire

/* File: tb/lcdpg_panel.sv */
// panel and key matrix model: decodes dot a of every line, makes a moving key source pattern
// assumes: driven by the common and line pins of lcdpg_top on the same clock
`timescale 1ns/1ps
`default_nettype none
module lcdpg_panel (
  // clock
  input wire logic clk,
  // pins
  input wire lcdpg_pkg::lcdpg_lvl_t com0,
  input wire logic [29:0] line,
  // key source and decoded dots
  output logic [15:0] keys,
  output logic [29:0] lit_a
);
  initial keys = 16'h0;
  // twisted ring changes every cycle, so stale scan data cannot pass
  // plain always: the start value comes from the initial block above
  always @(posedge clk) begin
    keys <= {keys[14:0], ~keys[15]};
  end
  // dot a lights when segment and com0 lie a full supply apart; half level keeps the last view
  always_ff @(posedge clk) begin
    if (com0 == lcdpg_pkg::LCDPG_LVL_FULL) begin
      lit_a <= ~line;
    end else if (com0 == lcdpg_pkg::LCDPG_LVL_GND) begin
      lit_a <= line;
    end
  end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench of lcdpg_top: apb tasks, panel model, one task per scenario
// assumes: design, lcdpg_panel and lcdpg_monitor compiled first
`timescale 1ns/1ps
`default_nettype none
`include "lcdpg_map.svh"
module testbench;
  localparam int unsigned PH = 20; // short slot, still above the scan window
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clkstop_rst = 1'b0;
  logic chipen_rst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [29:0] dot_a = 30'h0;
  logic [15:0] keys;
  logic [29:0] lit_a;
  lcdpg_pkg::lcdpg_lvl_t com0_ff;
  lcdpg_pkg::lcdpg_lvl_t com1_ff;
  logic [29:0] lcd_line_ff;
  logic scan_active_ff;
  int n_errors = 0;
  int checked = 0;
  always #5 clk = ~clk;
  lcdpg_top #(.PHASE_CYC(PH)) lcdpg_top_i (.clk, .rst, .clkstop_rst, .chipen_rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .dot_a, .dot_b(30'h15a5_a5a5),
    .scan_source_line(keys), .com0_ff, .com1_ff, .lcd_line_ff, .scan_active_ff);
  lcdpg_panel lcdpg_panel_i (.clk(clk), .com0(com0_ff), .line(lcd_line_ff), .keys(keys), .lit_a(lit_a));
  // ----------------
  // shared tasks
  // ----------------
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {22'h0, idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      $display("[FAIL] pready expected 1 seen %b", pready);
      end_sim();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so the next call never re-drives psel in this time step
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, idx, d, q, e);
  endtask
  task automatic rd(input string what, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, idx, 32'h0, q, e);
    chk(what, exp, q);
  endtask
  // ----------------
  // scenarios
  // ----------------
  task automatic t_reset_values();
    logic [31:0] q;
    logic e;
    rd("select after reset", `LCDPG_IDX_SEL, 32'h0);
    rd("mode after reset", `LCDPG_IDX_MODE, 32'h0);
    apb(1'b0, 8'h10, 32'h0, q, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    rd("status idle", `LCDPG_IDX_STATUS, 32'h0);
    apb(1'b1, `LCDPG_IDX_STATUS, 32'hf, q, e);
    chk("status write error", 32'h1, {31'h0, e});
    $display("t_reset_values done");
  endtask
  // every select code, display off: port groups show latches, the rest stay low
  task automatic t_groups();
    logic [29:0] lat;
    lat = {4'ha, 4'h5, 6'h2d, 16'hc3a5};
    wr(`LCDPG_IDX_PORT_F, 32'ha);
    wr(`LCDPG_IDX_PORT_E, 32'h5);
    wr(`LCDPG_IDX_PORT_X, 32'h2d);
    wr(`LCDPG_IDX_PORT_Y, 32'hc3a5);
    for (int k = 0; k < 16; k++) begin
      wr(`LCDPG_IDX_SEL, 32'(k));
      rd("select readback", `LCDPG_IDX_SEL, 32'(k));
      chk("group lines", 32'(lat & {{4{k[0]}}, {4{k[1]}}, {6{k[2]}}, {16{k[3]}}}), 32'(lcd_line_ff));
    end
    wr(`LCDPG_IDX_PORT_F, 32'h3);
    repeat (3) @(posedge clk);
    chk("latch follows", 32'h3, 32'(lcd_line_ff[29:26]));
    $display("t_groups done");
  endtask
  task automatic t_display();
    wr(`LCDPG_IDX_SEL, 32'h0);
    dot_a <= 30'h2a5c_3f01;
    wr(`LCDPG_IDX_MODE, 32'h1);
    repeat (6 * PH) @(posedge clk);
    chk("panel dots", 32'h2a5c_3f01, 32'(lit_a));
    wr(`LCDPG_IDX_MODE, 32'h0);
    repeat (3) @(posedge clk);
    chk("com0 off", 32'(lcdpg_pkg::LCDPG_LVL_GND), 32'(com0_ff));
    chk("com1 off", 32'(lcdpg_pkg::LCDPG_LVL_GND), 32'(com1_ff));
    chk("lines off", 32'h0, 32'(lcd_line_ff));
    $display("t_display done");
  endtask
  // count scan cycles over four slots; then port y over scan; then scan off
  task automatic t_scan();
    int seen;
    seen = 0;
    wr(`LCDPG_IDX_MODE, 32'h2);
    for (int i = 0; i < 4 * PH; i++) begin
      @(posedge clk);
      seen += (scan_active_ff === 1'b1);
    end
    chk("scan cycles", 32'(4 * `LCDPG_SCAN_WIN_CYC), 32'(seen));
    wr(`LCDPG_IDX_SEL, 32'h8);
    repeat (3) @(posedge clk);
    for (int i = 0; i < PH; i++) begin
      @(posedge clk);
      chk("port y over scan", 32'hc3a5, 32'(lcd_line_ff[15:0]));
    end
    wr(`LCDPG_IDX_SEL, 32'h0);
    wr(`LCDPG_IDX_MODE, 32'h0);
    seen = 0;
    for (int i = 0; i < 2 * PH; i++) begin
      @(posedge clk);
      seen += (scan_active_ff !== 1'b0);
    end
    chk("scan off", 32'h0, 32'(seen));
    $display("t_scan done");
  endtask
  task automatic t_resets();
    wr(`LCDPG_IDX_SEL, 32'hf);
    wr(`LCDPG_IDX_MODE, 32'h2);
    chipen_rst <= 1'b1;
    @(posedge clk);
    chipen_rst <= 1'b0;
    @(posedge clk);
    rd("select kept", `LCDPG_IDX_SEL, 32'hf);
    rd("mode kept", `LCDPG_IDX_MODE, 32'h2);
    clkstop_rst <= 1'b1;
    @(posedge clk);
    clkstop_rst <= 1'b0;
    @(posedge clk);
    rd("select cleared", `LCDPG_IDX_SEL, 32'h0);
    rd("mode cleared", `LCDPG_IDX_MODE, 32'h0);
    wr(`LCDPG_IDX_SEL, 32'h5);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd("select power-on", `LCDPG_IDX_SEL, 32'h0);
    $display("t_resets done");
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset_values();
    t_groups();
    t_display();
    t_scan();
    t_resets();
    end_sim();
  end
endmodule
bind lcdpg_top lcdpg_monitor #(.PHASE_CYC(PHASE_CYC)) lcdpg_monitor_i (.clk, .rst, .clkstop_rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .dot_a, .scan_source_line, .com0_ff, .com1_ff, .lcd_line_ff,
  .scan_active_ff);
`default_nettype wire
